/* src/hall_capture_consts.svh */
// Offsets, write masks, reset values and timing counts of the hall capture timer.
// Assumes a 125 MHz core clock and APB byte addresses on word boundaries.
// Function
// R01: Source selector picks hall or aux input
// R02: Edge field: off, rising, falling, both
// R03: Capture enable bit gates the source
// R04: Filter accepts after two or four samples
// R05: Filter samples every clock or four
// R06: Filter enable inserts or bypasses filter
// R07: Capture auto-reset clears counter after capture
// R08: Compare auto-reset clears counter on match
// R09: Sixteen bit counter as two bytes
// R10: Sixteen bit compare value, reset zero
// R11: Read-only capture bytes, loaded on capture
// R12: Qualified trigger copies counter, sets flag
// R13: Capture request needs flag and enable
// R14: Match sets flag, optional request
// R15: Master on bit enables counting
// R16: Bypass bit passes noise input through
// R17: Source bit selects threshold filter output
// R18: Filtered pin edge field selects event
// R19: Threshold filter rejects short pulses
// R20: Five-bit thresholds, bit five reads zero
// R21: Glitch filter on halls and filtered pin
// R22: Clock select: PWM or divided clock
// R23: Pause bit freezes counter value
// R24: Counter clears on timer turn-on
// R25: Counter increments per tick and wraps
`ifndef HALL_CAPTURE_CONSTS_SVH
`define HALL_CAPTURE_CONSTS_SVH
`define OFS_CTRL0        12'h000
`define OFS_CTRL1        12'h004
`define OFS_CNT_LO       12'h008
`define OFS_CNT_HI       12'h00C
`define OFS_CMP_LO       12'h010
`define OFS_CMP_HI       12'h014
`define OFS_CAP_LO       12'h018
`define OFS_CAP_HI       12'h01C
`define OFS_NF_HI        12'h020
`define OFS_NF_LO        12'h024
`define OFS_STATUS       12'h028
`define OFS_IRQ_EN       12'h02C
`define CTRL0_MASK       8'hFB
`define NF_MASK          8'hDF
`define NF_HI_RESET      8'h19
`define NF_LO_RESET      8'h0A
`define FILTER_UNIT_NS   5000
`define CLK_PERIOD_NS    8
`define FILTER_UNIT_CYC  (`FILTER_UNIT_NS / `CLK_PERIOD_NS)
`endif

/* src/hall_capture_pkg.sv */
// Types for the hall capture timer.
// Assumes the constants header is included by the design file.
package hall_capture_pkg;
  typedef struct packed {
    logic       timer_pause;
    logic [2:0] count_clock_select;
    logic       timer_on;
    logic       unused;
    logic [1:0] capture_source_select;
  } ctrl0_t;
  typedef struct packed {
    logic [1:0] capture_edge_select;
    logic       capture_input_enable;
    logic       glitch_sample_count;
    logic       glitch_sample_clock;
    logic       glitch_filter_enable;
    logic       clear_on_capture;
    logic       clear_on_match;
  } ctrl1_t;
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_mode_t;
endpackage : hall_capture_pkg

/* src/hall_capture_compare_timer.sv */
// Hall capture/compare timer with glitch and threshold noise filters, APB slave.
// Assumes inputs synchronous to core_clk_in and a one-cycle PWM tick input.
`timescale 1ns/1ps
`include "hall_capture_consts.svh"
module hall_capture_compare_timer
  import hall_capture_pkg::*;
#(
  parameter int unsigned FILTER_UNIT_CYCLES = `FILTER_UNIT_CYC
)(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // APB
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Sensor inputs
  input  wire logic        hall_input_1_in,
  input  wire logic        hall_input_2_in,
  input  wire logic        hall_input_3_in,
  input  wire logic        aux_capture_pin_in,
  input  wire logic        filtered_input_pin_in,
  input  wire logic        pwm_output_clock_in,
  // Interrupt requests
  output logic             capture_irq_out,
  output logic             match_irq_out,
  output logic             filtered_pin_irq_out
);
  ctrl0_t      ctrl0_reg;
  ctrl1_t      ctrl1_reg;
  logic [15:0] count_reg;
  logic [15:0] compare_reg;
  logic [15:0] capture_reg;
  logic [7:0]  nf_hi_reg;
  logic [7:0]  nf_lo_reg;
  logic        capture_event_flag_reg;
  logic        match_event_flag_reg;
  logic        filtered_pin_flag_reg;
  logic [2:0]  irq_en_reg;
  logic        on_d_reg;

  wire logic wr = psel_in & penable_in & pwrite_in;
  wire logic rd_go = psel_in & penable_in & ~pwrite_in;

  // Sample strobe: every clock or every fourth
  logic [1:0] pre4_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) pre4_reg <= 2'h0;
    else pre4_reg <= pre4_reg + 2'h1;
  // R05 sample interval
  wire logic sample_tick = ~ctrl1_reg.glitch_sample_clock | (pre4_reg == 2'h3);

  // Threshold noise filter on the filtered pin
  logic [31:0] nf_unit_reg;
  logic [4:0]  nf_cnt_reg;
  logic        nf_out_reg;
  wire  logic [4:0] nf_diff = nf_hi_reg[4:0] - nf_lo_reg[4:0];
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      nf_unit_reg <= 32'h0;
      nf_cnt_reg  <= 5'h0;
      nf_out_reg  <= 1'b0;
    end
    // R16 bypass path
    else if (nf_hi_reg[7] || nf_hi_reg[4:0] <= nf_lo_reg[4:0] || nf_diff <= 5'h1)
    begin
      nf_out_reg  <= filtered_input_pin_in;
      nf_cnt_reg  <= 5'h0;
      nf_unit_reg <= 32'h0;
    end
    else if (filtered_input_pin_in == nf_out_reg)
    begin
      nf_cnt_reg  <= 5'h0;
      nf_unit_reg <= 32'h0;
    end
    // R19 reject pulses shorter than diff units
    else if (nf_unit_reg + 32'h1 >= FILTER_UNIT_CYCLES)
    begin
      nf_unit_reg <= 32'h0;
      if (nf_cnt_reg + 5'h1 >= nf_diff)
      begin
        nf_out_reg <= filtered_input_pin_in;
        nf_cnt_reg <= 5'h0;
      end
      else nf_cnt_reg <= nf_cnt_reg + 5'h1;
    end
    else nf_unit_reg <= nf_unit_reg + 32'h1;

  // Glitch filter, one per input: halls 0..2, filtered pin 3
  logic [3:0] raw_in;
  logic [3:0] filt_out;
  // R17 filtered source select replaces hall 1 path
  assign raw_in = {nf_out_reg, hall_input_3_in, hall_input_2_in,
                   nf_hi_reg[6] ? nf_out_reg : hall_input_1_in};
  genvar gi;
  // R21 filter on all four inputs
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_glitch
      logic [3:0] hist_reg;
      logic       level_reg;
      always_ff @(posedge core_clk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
          hist_reg  <= 4'h0;
          level_reg <= 1'b0;
        end
        else if (sample_tick)
        begin
          hist_reg <= {hist_reg[2:0], raw_in[gi]};
          // R04 two or four equal samples
          if (ctrl1_reg.glitch_sample_count ? (&hist_reg | ~|hist_reg)
                                            : (&hist_reg[1:0] | ~|hist_reg[1:0]))
            level_reg <= hist_reg[0];
        end
      // R06 filter or bypass
      assign filt_out[gi] = ctrl1_reg.glitch_filter_enable ? level_reg : raw_in[gi];
    end
  endgenerate

  // R01 source selection
  logic sel_in;
  always_comb
  begin
    case (ctrl0_reg.capture_source_select)
      2'h0:    sel_in = filt_out[0];
      2'h1:    sel_in = filt_out[1];
      2'h2:    sel_in = filt_out[2];
      default: sel_in = aux_capture_pin_in;
    endcase
  end

  logic sel_d_reg;
  logic pin_d_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      sel_d_reg <= 1'b0;
      pin_d_reg <= 1'b0;
    end
    else
    begin
      sel_d_reg <= sel_in;
      pin_d_reg <= filt_out[3];
    end

  function automatic logic edge_hit(input logic [1:0] m, input logic now, input logic was);
    edge_hit = (m[0] & now & ~was) | (m[1] & ~now & was);
  endfunction : edge_hit

  // R02 R03 qualified trigger
  wire logic cap_trig = ctrl1_reg.capture_input_enable & ctrl0_reg.timer_on &
                        edge_hit(ctrl1_reg.capture_edge_select, sel_in, sel_d_reg);
  // R18 filtered pin event
  wire logic pin_trig = edge_hit(nf_lo_reg[7:6], filt_out[3], pin_d_reg);

  // Count clock tick
  logic [6:0] div_reg;
  logic       pwm_d_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      div_reg   <= 7'h0;
      pwm_d_reg <= 1'b0;
    end
    else
    begin
      div_reg   <= div_reg + 7'h1;
      pwm_d_reg <= pwm_output_clock_in;
    end
  logic count_tick;
  // R22 clock select
  always_comb
  begin
    if (ctrl0_reg.count_clock_select == 3'h0)
      count_tick = pwm_output_clock_in & ~pwm_d_reg;
    else
      count_tick = (div_reg & ((7'h1 << ctrl0_reg.count_clock_select) - 7'h1)) == 7'h0;
  end

  wire logic match = ctrl0_reg.timer_on && count_reg == compare_reg;
  // R15 R23 run condition
  wire logic run = ctrl0_reg.timer_on & ~ctrl0_reg.timer_pause & count_tick;

  // Counter
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) on_d_reg <= 1'b0;
    else on_d_reg <= ctrl0_reg.timer_on;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) count_reg <= 16'h0;
    // R24 clear on turn-on
    else if (ctrl0_reg.timer_on & ~on_d_reg) count_reg <= 16'h0;
    // R09 byte writes
    else if (wr && paddr_in == `OFS_CNT_LO) count_reg[7:0] <= pwdata_in[7:0];
    else if (wr && paddr_in == `OFS_CNT_HI) count_reg[15:8] <= pwdata_in[7:0];
    // R07 clear after capture
    else if (cap_trig & ctrl1_reg.clear_on_capture) count_reg <= 16'h0;
    // R08 clear on match
    // Cleared on the clock that sees equality, not on the next tick; pause still freezes
    else if (match & ctrl1_reg.clear_on_match & ~ctrl0_reg.timer_pause) count_reg <= 16'h0;
    // R25 count and wrap
    else if (run) count_reg <= count_reg + 16'h1;

  // R11 R12 capture copy
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) capture_reg <= 16'h0;
    else if (cap_trig) capture_reg <= count_reg;

  logic match_d_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) match_d_reg <= 1'b0;
    else match_d_reg <= match;

  // Flags: write one to clear, set wins
  wire logic st_wr = wr && paddr_in == `OFS_STATUS;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      capture_event_flag_reg <= 1'b0;
      match_event_flag_reg   <= 1'b0;
      filtered_pin_flag_reg  <= 1'b0;
    end
    else
    begin
      // R12 capture flag
      capture_event_flag_reg <= cap_trig |
        (capture_event_flag_reg & ~(st_wr & pwdata_in[0]));
      // R14 match flag on reaching compare
      match_event_flag_reg <= (match & ~match_d_reg) |
        (match_event_flag_reg & ~(st_wr & pwdata_in[1]));
      filtered_pin_flag_reg <= pin_trig |
        (filtered_pin_flag_reg & ~(st_wr & pwdata_in[2]));
    end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      capture_irq_out      <= 1'b0;
      match_irq_out        <= 1'b0;
      filtered_pin_irq_out <= 1'b0;
    end
    else
    begin
      // R13 capture request gating
      capture_irq_out      <= capture_event_flag_reg & irq_en_reg[0];
      // R14 match request gating
      match_irq_out        <= match_event_flag_reg & irq_en_reg[1];
      filtered_pin_irq_out <= filtered_pin_flag_reg & irq_en_reg[2];
    end

  // Control register writes
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      ctrl0_reg   <= '0;
      ctrl1_reg   <= '0;
      compare_reg <= 16'h0;
      nf_hi_reg   <= `NF_HI_RESET;
      nf_lo_reg   <= `NF_LO_RESET;
      irq_en_reg  <= 3'h0;
    end
    else if (wr)
    begin
      if (paddr_in == `OFS_CTRL0) ctrl0_reg <= ctrl0_t'(pwdata_in[7:0] & `CTRL0_MASK);
      else if (paddr_in == `OFS_CTRL1) ctrl1_reg <= ctrl1_t'(pwdata_in[7:0]);
      // R10 compare bytes
      else if (paddr_in == `OFS_CMP_LO) compare_reg[7:0] <= pwdata_in[7:0];
      else if (paddr_in == `OFS_CMP_HI) compare_reg[15:8] <= pwdata_in[7:0];
      // R20 bit five held zero
      else if (paddr_in == `OFS_NF_HI) nf_hi_reg <= pwdata_in[7:0] & `NF_MASK;
      else if (paddr_in == `OFS_NF_LO) nf_lo_reg <= pwdata_in[7:0] & `NF_MASK;
      else if (paddr_in == `OFS_IRQ_EN) irq_en_reg <= pwdata_in[2:0];
    end

  // Read path, registered; zero-wait answer
  logic [7:0] rd_byte;
  logic       rd_err;
  always_comb
  begin
    rd_err = 1'b0;
    if (paddr_in == `OFS_CTRL0) rd_byte = ctrl0_reg;
    else if (paddr_in == `OFS_CTRL1) rd_byte = ctrl1_reg;
    else if (paddr_in == `OFS_CNT_LO) rd_byte = count_reg[7:0];
    else if (paddr_in == `OFS_CNT_HI) rd_byte = count_reg[15:8];
    else if (paddr_in == `OFS_CMP_LO) rd_byte = compare_reg[7:0];
    else if (paddr_in == `OFS_CMP_HI) rd_byte = compare_reg[15:8];
    else if (paddr_in == `OFS_CAP_LO) rd_byte = capture_reg[7:0];
    else if (paddr_in == `OFS_CAP_HI) rd_byte = capture_reg[15:8];
    else if (paddr_in == `OFS_NF_HI) rd_byte = nf_hi_reg;
    else if (paddr_in == `OFS_NF_LO) rd_byte = nf_lo_reg;
    else if (paddr_in == `OFS_STATUS)
      rd_byte = {5'h0, filtered_pin_flag_reg, match_event_flag_reg, capture_event_flag_reg};
    else if (paddr_in == `OFS_IRQ_EN) rd_byte = {5'h0, irq_en_reg};
    else
    begin
      rd_byte = 8'h0;
      rd_err  = 1'b1;
    end
  end

  // Setup-phase sampling lets data meet the access phase from a flop
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
      pready_out  <= 1'b0;
    end
    else
    begin
      prdata_out  <= {24'h0, rd_byte};
      pslverr_out <= psel_in & ~penable_in & rd_err;
      pready_out  <= psel_in & ~penable_in;
    end

  // R12 capture copies the counter
  property p_capture_copy;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      cap_trig |=> capture_reg == $past(count_reg) && capture_event_flag_reg;
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture copy wrong"); // R12
  property p_clear_cap;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      cap_trig && ctrl1_reg.clear_on_capture && on_d_reg && !wr |=> count_reg == 16'h0;
  endproperty
  a_clear_cap: assert property (p_clear_cap) else $error("no clear after capture"); // R07
  property p_clear_match;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      match && !ctrl0_reg.timer_pause && ctrl1_reg.clear_on_match && on_d_reg && !wr && !cap_trig
      |=> count_reg == 16'h0;
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("no clear on match"); // R08
  property p_no_cap_disabled;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      !ctrl1_reg.capture_input_enable |-> !cap_trig;
  endproperty
  a_no_cap_disabled: assert property (p_no_cap_disabled) else $error("capture leaked"); // R03
  property p_pause_hold;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      ctrl0_reg.timer_pause && on_d_reg && !wr && !cap_trig |=> $stable(count_reg);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("counter moved in pause"); // R23
  property p_turn_on;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(ctrl0_reg.timer_on) |=> count_reg == 16'h0;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("counter not cleared on turn-on"); // R24
  property p_off_hold;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      !ctrl0_reg.timer_on && !wr ##1 !ctrl0_reg.timer_on |-> $stable(count_reg);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counter ran while off"); // R15
  property p_cap_irq;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      capture_irq_out |-> $past(capture_event_flag_reg) && $past(irq_en_reg[0]);
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("stray capture request"); // R13
  property p_nf_mask;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      !nf_hi_reg[5] && !nf_lo_reg[5];
  endproperty
  a_nf_mask: assert property (p_nf_mask) else $error("threshold bit five set"); // R20
  property p_match_flag;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      match && !match_d_reg |=> match_event_flag_reg;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set"); // R14
  property p_nf_bypass;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      nf_hi_reg[7] |=> nf_out_reg == $past(filtered_input_pin_in);
  endproperty
  a_nf_bypass: assert property (p_nf_bypass) else $error("noise filter not bypassed"); // R16
endmodule : hall_capture_compare_timer

/* tb/hall_sensor_model.sv */
// Sensor side of the capture timer: three hall lines, aux pin, filtered pin, PWM tick.
// Assumes the bench calls the tasks from one process, just after a clock edge.
`timescale 1ns/1ps
module hall_sensor_model (
  // Clock
  input  wire logic       core_clk_in,
  // Levels: hall 1..3, aux pin, filtered pin
  output logic      [4:0] level_out,
  // Count tick
  output logic            pwm_tick_out
);
  initial
  begin
    level_out    = 5'h00;
    pwm_tick_out = 1'b0;
  end

  task automatic set_level(input int idx, input logic val);
    @(posedge core_clk_in);
    level_out[idx] <= val;
  endtask : set_level

  // Gap between pulses so every tick is a fresh rising edge
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge core_clk_in);
      pwm_tick_out <= 1'b1;
      @(posedge core_clk_in);
      pwm_tick_out <= 1'b0;
    end
  endtask : ticks
endmodule : hall_sensor_model

/* tb/hall_capture_compare_timer_tb_top.sv */
// Self-checking bench for the hall capture/compare timer, driven over APB.
// Assumes a zero-wait APB slave and the sensor model on the capture inputs.
`timescale 1ns/1ps
`include "hall_capture_consts.svh"
module hall_capture_compare_timer_tb_top;
  logic        core_clk_in;
  logic        rst_n_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [4:0]  level;
  logic        pwm_tick;
  logic        capture_irq_out;
  logic        match_irq_out;
  logic        filtered_pin_irq_out;
  logic [31:0] q;
  logic [31:0] p;
  logic        e;
  int          err_count;
  int          total_checks;
  int          cycles;

  hall_capture_compare_timer #(.FILTER_UNIT_CYCLES(4)) i_hall_capture_compare_timer (
    .core_clk_in          (core_clk_in),
    .rst_n_in             (rst_n_in),
    .psel_in              (psel_in),
    .penable_in           (penable_in),
    .pwrite_in            (pwrite_in),
    .paddr_in             (paddr_in),
    .pwdata_in            (pwdata_in),
    .prdata_out           (prdata_out),
    .pready_out           (pready_out),
    .pslverr_out          (pslverr_out),
    .hall_input_1_in      (level[0]),
    .hall_input_2_in      (level[1]),
    .hall_input_3_in      (level[2]),
    .aux_capture_pin_in   (level[3]),
    .filtered_input_pin_in(level[4]),
    .pwm_output_clock_in  (pwm_tick),
    .capture_irq_out      (capture_irq_out),
    .match_irq_out        (match_irq_out),
    .filtered_pin_irq_out (filtered_pin_irq_out)
  );

  hall_sensor_model i_hall_sensor_model (
    .core_clk_in (core_clk_in),
    .level_out   (level),
    .pwm_tick_out(pwm_tick)
  );

  always #4 core_clk_in = ~core_clk_in;

  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // A hang counts as a mismatch
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Setup cycle, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    psel_in    <= 1'b1;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= {24'h000000, d};
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    @(posedge core_clk_in);
    while (pready_out !== 1'b1)
      @(posedge core_clk_in);
    q = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, q, exp);
  endtask : rd

  initial
  begin
    core_clk_in  = 1'b0;
    rst_n_in     = 1'b0;
    psel_in      = 1'b0;
    penable_in   = 1'b0;
    pwrite_in    = 1'b0;
    paddr_in     = 12'h000;
    pwdata_in    = 32'h00000000;
    err_count    = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd("ctrl0", `OFS_CTRL0, 32'h0);
    rd("ctrl1", `OFS_CTRL1, 32'h0);
    rd("cnt lo", `OFS_CNT_LO, 32'h0);
    rd("cnt hi", `OFS_CNT_HI, 32'h0);
    rd("cmp lo", `OFS_CMP_LO, 32'h0);
    rd("cmp hi", `OFS_CMP_HI, 32'h0);
    rd("nf hi", `OFS_NF_HI, 32'(`NF_HI_RESET));
    rd("nf lo", `OFS_NF_LO, 32'(`NF_LO_RESET));
    apb(1'b0, 12'h030, 8'h00);
    chk("unmapped err", 32'(e), 32'h1);
    wr(`OFS_NF_HI, 8'hFF);
    rd("nf hi", `OFS_NF_HI, 32'hDF);
    // Bit six left set would steer hall 1 to the noise filter output
    wr(`OFS_NF_HI, `NF_HI_RESET);
    wr(`OFS_CAP_LO, 8'h55);
    rd("cap lo", `OFS_CAP_LO, 32'h0);
    wr(`OFS_CNT_LO, 8'h34);
    wr(`OFS_CNT_HI, 8'h12);
    rd("cnt lo", `OFS_CNT_LO, 32'h34);
    rd("cnt hi", `OFS_CNT_HI, 32'h12);
    wr(`OFS_CMP_HI, 8'hAB);
    rd("cmp hi", `OFS_CMP_HI, 32'hAB);
    // Turn on with divided clock: counter restarts from zero
    wr(`OFS_CTRL0, 8'h18);
    rd("cnt hi on", `OFS_CNT_HI, 32'h0);
    apb(1'b0, `OFS_CNT_LO, 8'h00);
    p = q;
    // Three clocks per read against a divide-by-two tick: one step here
    apb(1'b0, `OFS_CNT_LO, 8'h00);
    chk("count step", q - p, 32'h1);
    chk("counting", 32'(q != p), 32'h1);
    wr(`OFS_CTRL0, 8'h98);
    apb(1'b0, `OFS_CNT_LO, 8'h00);
    p = q;
    rd("paused", `OFS_CNT_LO, p);
    wr(`OFS_CTRL0, 8'h10);
    rd("off residual", `OFS_CNT_LO, p);
    // Compare 5 on PWM ticks with clear on match
    wr(`OFS_CMP_HI, 8'h00);
    wr(`OFS_CMP_LO, 8'h05);
    wr(`OFS_CTRL1, 8'h01);
    wr(`OFS_IRQ_EN, 8'h02);
    wr(`OFS_CTRL0, 8'h08);
    i_hall_sensor_model.ticks(4);
    rd("status", `OFS_STATUS, 32'h0);
    i_hall_sensor_model.ticks(1);
    rd("match", `OFS_STATUS, 32'h2);
    chk("match irq", 32'(match_irq_out), 32'h1);
    rd("cleared", `OFS_CNT_LO, 32'h0);
    i_hall_sensor_model.ticks(3);
    rd("cnt lo", `OFS_CNT_LO, 32'h3);
    wr(`OFS_STATUS, 8'h02);
    rd("status", `OFS_STATUS, 32'h0);
    wr(`OFS_CMP_HI, 8'hFF);
    // Source i with edge mode i; aux also clears on capture
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_CTRL0, 8'h00);
      wr(`OFS_CTRL1, {i[1:0], 4'h8, i == 3, 1'b0});
      wr(`OFS_CTRL0, {6'h02, i[1:0]});
      i_hall_sensor_model.ticks(i + 2);
      i_hall_sensor_model.set_level(i, 1'b1);
      rd("rise", `OFS_STATUS, 32'(i % 2));
      if (i % 2 == 1)
        rd("capture", `OFS_CAP_LO, 32'(i + 2));
      if (i == 3)
        rd("clr cap", `OFS_CNT_LO, 32'h0);
      wr(`OFS_STATUS, 8'h01);
      i_hall_sensor_model.ticks(1);
      i_hall_sensor_model.set_level(i, 1'b0);
      rd("fall", `OFS_STATUS, 32'(i / 2));
      if (i >= 2)
        rd("capture", `OFS_CAP_LO, (i == 3) ? 32'h1 : 32'h5);
      wr(`OFS_STATUS, 8'h01);
    end
    wr(`OFS_CTRL1, 8'hC0);
    i_hall_sensor_model.set_level(3, 1'b1);
    rd("cap off", `OFS_STATUS, 32'h0);
    wr(`OFS_CTRL1, 8'hE0);
    i_hall_sensor_model.set_level(3, 1'b0);
    rd("cap flag", `OFS_STATUS, 32'h1);
    chk("cap irq", 32'(capture_irq_out), 32'h0);
    wr(`OFS_IRQ_EN, 8'h03);
    rd("cap flag", `OFS_STATUS, 32'h1);
    chk("cap irq", 32'(capture_irq_out), 32'h1);
    // Glitch filter: four samples every fourth clock, then two every clock
    wr(`OFS_CTRL0, 8'h08);
    wr(`OFS_CTRL1, 8'hFC);
    wr(`OFS_STATUS, 8'h01);
    i_hall_sensor_model.set_level(0, 1'b1);
    repeat (6) @(posedge core_clk_in);
    i_hall_sensor_model.set_level(0, 1'b0);
    repeat (20) @(posedge core_clk_in);
    rd("short pulse", `OFS_STATUS, 32'h0);
    i_hall_sensor_model.set_level(0, 1'b1);
    repeat (30) @(posedge core_clk_in);
    rd("long pulse", `OFS_STATUS, 32'h1);
    wr(`OFS_CTRL1, 8'hE4);
    wr(`OFS_STATUS, 8'h01);
    i_hall_sensor_model.set_level(0, 1'b0);
    i_hall_sensor_model.set_level(0, 1'b1);
    repeat (8) @(posedge core_clk_in);
    rd("one cycle", `OFS_STATUS, 32'h0);
    // Filtered pin: bypassed threshold filter, rising-edge request
    wr(`OFS_NF_HI, 8'h80);
    wr(`OFS_NF_LO, 8'h40);
    wr(`OFS_IRQ_EN, 8'h07);
    wr(`OFS_STATUS, 8'h07);
    i_hall_sensor_model.set_level(4, 1'b1);
    repeat (4) @(posedge core_clk_in);
    rd("pin flag", `OFS_STATUS, 32'h4);
    chk("pin irq", 32'(filtered_pin_irq_out), 32'h1);
    wr(`OFS_NF_HI, 8'hC0);
    wr(`OFS_STATUS, 8'h07);
    i_hall_sensor_model.set_level(4, 1'b0);
    repeat (4) @(posedge core_clk_in);
    rd("pin capture", `OFS_STATUS, 32'h1);
    print_verdict();
  end
endmodule : hall_capture_compare_timer_tb_top
